// ---- rtl/tcc_core.sv ----
// timer counter core: status/control, counter, latched reads, modulo
// assumes synchronous inputs and a one-cycle-latency register port
// How it works
// - stop mode blocks counting and register writes, registers and counter keep values
// - break halts the counter
// - with break clear enable 1, clears during break take effect
// - with break clear enable 0, break accesses leave the overflow flag and its clear sequence unchanged
// - three-bit select picks bus divide 1..64 or external clock
// - channel zero pin forced input when it clocks the counter
// - six channels configurable; zero, two, four buffered (outside core)
// - overflow flag clears by read-with-flag-set then write 0
// - irq when flag and enable set; reset clears both
// - halt bit stops counting; reset sets halt
// - halt bit inhibits input captures
// - counter reset bit clears counter and prescaler, reads 0
// - halt plus counter reset leaves counter halted at zero
// - high byte read latches low byte until low read
// - counter cleared by reset and by counter reset bit
// - low latch survives a break end if unread
// - counter equal to modulo sets flag and restarts at zero
// - modulo high write suppresses overflow until low write
// - reset sets modulo registers to all ones
// - timer runs in wait mode; enabled irq wakes processor
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tcc_core (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  tcc_pkg::tcc_req_t      req,
    output logic [7:0]             rdata,
    // system mode inputs
    input  wire logic              stop_mode,
    input  wire logic              break_active,
    input  wire logic              break_clear_enable,
    // pins
    input  wire logic              channel_zero_pin,
    output logic                   channel_zero_force_input,
    // channel side and interrupt
    output tcc_pkg::tcc_cnt_t      cnt_out,
    output logic                   capture_inhibit,
    output logic                   overflow_irq
);
    import tcc_pkg::*;

    logic        overflow_flag_reg;
    logic        overflow_irq_enable_reg;
    logic        counter_halt_reg;
    logic [2:0]  clock_prescale_select_reg;
    logic [15:0] count_reg;
    logic [7:0]  lo_latch_reg;
    logic        lo_latched_reg;
    logic [7:0]  rdata_reg;
    tcc_clr_t    clr_reg;
    tcc_clr_t    clr_next;

    logic        sel_status;
    logic        sel_cnt_hi;
    logic        sel_cnt_lo;
    logic        sel_mod_hi;
    logic        sel_mod_lo;
    logic        wr_status;
    logic        rd_status;
    logic        rd_cnt_hi;
    logic        rd_cnt_lo;
    logic        status_touch_ok;
    logic        crst;
    logic        run;
    logic        tick;
    logic        at_modulo;
    logic        ovf_evt;
    logic        ovf_clear;
    logic [15:0] modulo;
    logic        mod_inhibit;
    logic [7:0]  status_view;
    logic [7:0]  rd_mux;

    // address decode
    assign sel_status = (req.addr == `TCC_OFS_STATUS);
    assign sel_cnt_hi = (req.addr == `TCC_OFS_CNT_HI);
    assign sel_cnt_lo = (req.addr == `TCC_OFS_CNT_LO);
    assign sel_mod_hi = (req.addr == `TCC_OFS_MOD_HI);
    assign sel_mod_lo = (req.addr == `TCC_OFS_MOD_LO);
    assign wr_status  = req.wr & sel_status;
    assign rd_status  = req.rd & sel_status;
    assign rd_cnt_hi  = req.rd & sel_cnt_hi;
    assign rd_cnt_lo  = req.rd & sel_cnt_lo;

    // clears allowed in break only with enable; else frozen
    assign status_touch_ok = ~break_active | break_clear_enable;

    // write-only reset strobe, never stored; ignored in stop
    assign crst = wr_status & ~stop_mode & req.wdata[`TCC_BIT_CRST];

    // stop mode; break; halt bit all stop counting
    assign run = ~counter_halt_reg & ~break_active & ~stop_mode;

    // channel zero pin treated as input when it is the clock
    assign channel_zero_force_input =
        (clock_prescale_select_reg == `TCC_PS_EXT);

    assign capture_inhibit = counter_halt_reg;

    tcc_prescale u_pre (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (crst),
        .run     (run),
        .sel     (clock_prescale_select_reg),
        .ext_clk (channel_zero_pin),
        .tick    (tick)
    );

    tcc_regs u_mod (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_hi   (req.wr & sel_mod_hi & ~stop_mode),
        .wr_lo   (req.wr & sel_mod_lo & ~stop_mode),
        .wdata   (req.wdata),
        .modulo  (modulo),
        .inhibit (mod_inhibit)
    );

    // overflow when counter equals modulo on a tick
    assign at_modulo = (count_reg == modulo);
    assign ovf_evt   = tick & at_modulo & ~crst;

    // second step is a write of 0 to the flag after an armed read
    assign ovf_clear = wr_status & ~req.wdata[`TCC_BIT_OVF] &
                       (clr_reg == TCC_CLR_ARMED) & status_touch_ok &
                       ~stop_mode;

    // clear sequence arming; no arming or disarm in break without enable; stop blocks only disarm
    always_comb begin
        clr_next = clr_reg;
        case (clr_reg)
            TCC_CLR_IDLE: begin
                if (rd_status && overflow_flag_reg && status_touch_ok)
                    clr_next = TCC_CLR_ARMED;
            end
            TCC_CLR_ARMED: begin
                if (ovf_evt || ovf_clear)
                    clr_next = TCC_CLR_IDLE;
            end
            default: clr_next = TCC_CLR_IDLE;
        endcase
    end

    // sixteen-bit counter; cleared by reset bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= `TCC_CNT_RESET;
        end else if (crst) begin
            count_reg <= `TCC_CNT_RESET;
        end else if (tick) begin
            count_reg <= at_modulo ? `TCC_CNT_RESET
                                   : count_reg + 16'h0001;
        end
    end

    // set wins over clear; inhibit blocks the set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_flag_reg <= 1'b0;
            clr_reg           <= TCC_CLR_IDLE;
        end else begin
            clr_reg <= clr_next;
            if (ovf_evt && !mod_inhibit)
                overflow_flag_reg <= 1'b1;
            else if (ovf_clear)
                overflow_flag_reg <= 1'b0;
        end
    end

    // control bits, halt set by reset, enable cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_irq_enable_reg   <= 1'b0;
            counter_halt_reg          <= 1'b1;
            clock_prescale_select_reg <= `TCC_PS_RESET;
        end else if (wr_status && !stop_mode) begin
            overflow_irq_enable_reg   <= req.wdata[`TCC_BIT_OVF_IE];
            counter_halt_reg          <= req.wdata[`TCC_BIT_HALT];
            clock_prescale_select_reg <=
                req.wdata[`TCC_PS_HI:`TCC_PS_LO];
        end
    end

    // high read latches low byte until low read; kept
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_latch_reg   <= 8'h00;
            lo_latched_reg <= 1'b0;
        end else if (rd_cnt_hi && !lo_latched_reg) begin
            lo_latch_reg   <= count_reg[7:0];
            lo_latched_reg <= 1'b1;
        end else if (rd_cnt_lo) begin
            lo_latched_reg <= 1'b0;
        end
    end

    // status view; reset bit always reads 0
    assign status_view = {overflow_flag_reg, overflow_irq_enable_reg,
                          counter_halt_reg, 1'b0, 1'b0,
                          clock_prescale_select_reg};

    // read select, unmapped reads 0
    assign rd_mux = sel_status ? status_view :
                    sel_cnt_hi ? count_reg[15:8] :
                    sel_cnt_lo ? (lo_latched_reg ? lo_latch_reg
                                                 : count_reg[7:0]) :
                    sel_mod_hi ? modulo[15:8] :
                    sel_mod_lo ? modulo[7:0] : 8'h00;

    // read data one cycle after strobe, then zero
    always_ff @(posedge clk) begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= req.rd ? rd_mux : 8'h00;
    end
    assign rdata = rdata_reg;

    // irq level; stays live in wait mode
    assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;

    // one counter view shared by all six channels
    assign cnt_out.count   = count_reg;
    assign cnt_out.ovf_evt = ovf_evt;
    assign cnt_out.halted  = ~run;
endmodule

// ---- inc/tcc_cfg.svh ----
// timer core constants: register offsets, field positions, reset values
// assumes inclusion by the package and the design files
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register offsets on the plain register port
`define TCC_ADDR_W        3
`define TCC_OFS_STATUS    3'h0
`define TCC_OFS_CNT_HI    3'h1
`define TCC_OFS_CNT_LO    3'h2
`define TCC_OFS_MOD_HI    3'h3
`define TCC_OFS_MOD_LO    3'h4

// status/control field positions
`define TCC_BIT_OVF       7
`define TCC_BIT_OVF_IE    6
`define TCC_BIT_HALT      5
`define TCC_BIT_CRST      4
`define TCC_PS_HI         2
`define TCC_PS_LO         0

// reset values, external clock select code and prescaler width
`define TCC_PS_RESET      3'h0
`define TCC_MOD_RESET     16'hFFFF
`define TCC_CNT_RESET     16'h0000
`define TCC_PS_EXT        3'h7
`define TCC_PRE_W         6

`endif

// ---- inc/tcc_pkg.sv ----
// timer core types
// assumes tcc_cfg.svh is on the include path
package tcc_pkg;
    `include "tcc_cfg.svh"

    // register port request
    typedef struct packed {
        logic [`TCC_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } tcc_req_t;

    // channel-facing counter view
    typedef struct packed {
        logic [15:0] count;
        logic        ovf_evt;
        logic        halted;
    } tcc_cnt_t;

    // two-step clear sequence states
    typedef enum logic [1:0] {
        TCC_CLR_IDLE  = 2'b00,
        TCC_CLR_ARMED = 2'b01
    } tcc_clr_t;
endpackage

// ---- rtl/tcc_prescale.sv ----
// timer core prescaler and external clock edge detection
// assumes ext pin already synchronous to clk
`timescale 1ns/1ps
module tcc_prescale (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       clr,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    input  wire logic       ext_clk,
    // tick out
    output logic            tick
);
    import tcc_pkg::*;

    logic [`TCC_PRE_W-1:0] div_reg;
    logic                  ext_reg;
    logic                  div_tick;
    logic                  ext_rise;

    // divider taps: code n below 7 ticks every 2^n bus clocks
    assign div_tick = (sel == 3'h0) ? 1'b1 :
        ((div_reg & ((`TCC_PRE_W'(1) << sel) - `TCC_PRE_W'(1)))
         == `TCC_PRE_W'(0));
    assign ext_rise = ext_clk & ~ext_reg;
    assign tick = run & ((sel == `TCC_PS_EXT) ? ext_rise : div_tick);

    // free divider, cleared with counter reset, frozen when halted;
    // pin history keeps tracking so a reset bit makes no false edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= '0;
            ext_reg <= 1'b0;
        end else begin
            ext_reg <= ext_clk;
            if (clr)
                div_reg <= '0;
            else if (run)
                div_reg <= div_reg + `TCC_PRE_W'(1);
        end
    end
endmodule

// ---- rtl/tcc_regs.sv ----
// timer core modulo registers with overflow inhibit during byte pair write
// assumes single-cycle write strobe
`timescale 1ns/1ps
module tcc_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // writes
    input  wire logic        wr_hi,
    input  wire logic        wr_lo,
    input  wire logic [7:0]  wdata,
    // state
    output logic [15:0]      modulo,
    output logic             inhibit
);
    import tcc_pkg::*;

    logic [15:0] mod_reg;
    logic        inh_reg;

    assign modulo  = mod_reg;
    assign inhibit = inh_reg;

    // reset sets all bits; high write inhibits until low write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod_reg <= `TCC_MOD_RESET;
            inh_reg <= 1'b0;
        end else begin
            if (wr_hi) begin
                mod_reg[15:8] <= wdata;
                inh_reg       <= 1'b1;
            end
            if (wr_lo) begin
                mod_reg[7:0] <= wdata;
                inh_reg      <= 1'b0;
            end
        end
    end
endmodule

// ---- verif/tcc_core_sva.sv ----
// port checker for the timer core
// assumes it is bound onto tcc_core, one clock domain
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_core_sva (
    // clock and reset
    input wire logic            clk,
    input wire logic            rst_n,
    // register port
    input tcc_pkg::tcc_req_t    req,
    input wire logic [7:0]      rdata,
    // system and pins
    input wire logic            stop_mode,
    input wire logic            break_active,
    input wire logic            channel_zero_force_input,
    // channel side
    input tcc_pkg::tcc_cnt_t    cnt_out,
    input wire logic            capture_inhibit,
    input wire logic            overflow_irq
);
    import tcc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // accepted status writes
    wire ctl_wr  = req.wr && req.addr == `TCC_OFS_STATUS && !stop_mode;
    wire crst_wr = ctl_wr && req.wdata[`TCC_BIT_CRST];
    sequence s_ctl_wr; ctl_wr; endsequence
    sequence s_rd_status; req.rd && req.addr == `TCC_OFS_STATUS; endsequence
    a_crst_zero: assert property (
        crst_wr |=> cnt_out.count == 16'h0000) else $error("count not zeroed");
    a_crst_reads0: assert property (
        s_rd_status |=> !rdata[`TCC_BIT_CRST]) else $error("reset bit read 1");
    a_stop_halt: assert property (
        stop_mode |-> cnt_out.halted) else $error("runs in stop mode");
    a_brk_halt: assert property (
        break_active |-> cnt_out.halted) else $error("runs in break");
    a_halt_keep: assert property (
        cnt_out.halted && !crst_wr |=> $stable(cnt_out.count))
        else $error("halted count moved");
    a_step_one: assert property (
        !cnt_out.halted && !cnt_out.ovf_evt && !crst_wr |=>
        $stable(cnt_out.count) ||
        cnt_out.count == $past(cnt_out.count) + 16'h0001)
        else $error("count step wrong");
    a_wrap_zero: assert property (
        cnt_out.ovf_evt |=> cnt_out.count == 16'h0000)
        else $error("no restart at zero");
    a_cap_inh: assert property (
        capture_inhibit |-> cnt_out.halted) else $error("capture inhibit");
    a_rst_state: assert property (
        $rose(rst_n) |-> !overflow_irq && cnt_out.halted)
        else $error("reset state wrong");
    a_ext_input: assert property (
        s_ctl_wr |=> channel_zero_force_input ==
        ($past(req.wdata[2:0]) == `TCC_PS_EXT)) else $error("pin direction");
    a_cap_follow: assert property (
        s_ctl_wr |=> capture_inhibit == $past(req.wdata[`TCC_BIT_HALT]))
        else $error("capture inhibit not halt bit");
endmodule
bind tcc_core tcc_core_sva chk_u (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .stop_mode(stop_mode), .break_active(break_active),
    .channel_zero_force_input(channel_zero_force_input),
    .cnt_out(cnt_out), .capture_inhibit(capture_inhibit),
    .overflow_irq(overflow_irq));

// ---- verif/tb.sv ----
// self-checking bench for the timer core
// assumes the core answers reads one cycle after the strobe
`timescale 1ns/1ps
`include "tcc_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import tcc_pkg::*;
    logic        clk, rst_n, stop_mode, break_active, bce, pin;
    logic        force_in, cap_inh, irq;
    logic [7:0]  rdata, d, h, l1;
    logic [15:0] c;
    tcc_req_t    req;
    tcc_cnt_t    cnt;
    int          err_total, num_checks;
    // device under test
    tcc_core dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(bce), .channel_zero_pin(pin),
        .channel_zero_force_input(force_in), .cnt_out(cnt),
        .capture_inhibit(cap_inh), .overflow_irq(irq));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_cnt(output logic [15:0] v);
        rd(`TCC_OFS_CNT_HI, v[15:8]);
        rd(`TCC_OFS_CNT_LO, v[7:0]);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        rd(0, d);
        `CHK(d, 8'h20)
        rd(3, d);
        `CHK(d, 8'hFF)
        rd(4, d);
        `CHK(d, 8'hFF)
        wr(2, 8'h55);
        rd_cnt(c);
        `CHK(c, 16'h0000)
        rd(5, d);
        `CHK(d, 8'h00)
        `CHK(irq, 1'b0)
        `CHK(cap_inh, 1'b1)
        `CHK(force_in, 1'b0)
    endtask
    task automatic t_div;
        for (int i = 0; i < 7; i++) begin
            wr(0, 8'h30);
            wr(0, 8'(i));
            cyc(16 << i);
            wr(0, 8'h20);
            rd_cnt(c);
            `CHK(c >= 16'h000F && c <= 16'h0013, 1'b1)
        end
    endtask
    task automatic t_ext;
        wr(0, 8'h37);
        `CHK(force_in, 1'b1)
        wr(0, 8'h07);
        repeat (5) begin
            pin <= 1'b1;
            cyc(4);
            pin <= 1'b0;
            cyc(4);
        end
        wr(0, 8'h27);
        rd_cnt(c);
        `CHK(c, 16'h0005)
    endtask
    task automatic t_latch;
        wr(0, 8'h10);
        cyc(20);
        rd(1, h);
        cyc(30);
        rd(1, h);
        rd(2, l1);
        wr(0, 8'h20);
        rd_cnt(c);
        `CHK(c[7:0] - l1 >= 8'h1E && c[7:0] - l1 <= 8'h2D, 1'b1)
        wr(0, 8'h30);
        cyc(5);
        rd_cnt(c);
        `CHK(c, 16'h0000)
    endtask
    task automatic t_ovf;
        wr(0, 8'h30);
        wr(3, 8'h00);
        wr(0, 8'h00);
        cyc(600);
        rd(0, d);
        `CHK(d[7], 1'b0)
        // clear again before the low byte
        wr(0, 8'h30);
        wr(4, 8'h04);
        wr(0, 8'h10);
        cyc(20);
        rd(0, d);
        `CHK(d, 8'h80)
        `CHK(irq, 1'b0)
        // a written 1 leaves the armed flag set
        wr(0, 8'hE0);
        `CHK(irq, 1'b1)
        rd(0, d);
        wr(0, 8'h60);
        rd(0, d);
        `CHK(d, 8'h60)
        `CHK(irq, 1'b0)
        wr(0, 8'hE0);
        rd(0, d);
        `CHK(d, 8'h60)
        // halt kept clear while the irq is wanted
        wr(0, 8'h40);
        cyc(10);
        rd(0, d);
        cyc(10);
        wr(0, 8'h60);
        rd(0, d);
        `CHK(d[7], 1'b1)
    endtask
    task automatic t_brk;
        rd(0, d);
        break_active <= 1'b1;
        wr(0, 8'h60);
        rd(0, d);
        `CHK(d[7], 1'b1)
        break_active <= 1'b0;
        wr(0, 8'h60);
        rd(0, d);
        `CHK(d[7], 1'b0)
        wr(0, 8'h40);
        cyc(10);
        wr(0, 8'h60);
        bce <= 1'b1;
        break_active <= 1'b1;
        rd(0, d);
        wr(0, 8'h60);
        break_active <= 1'b0;
        rd(0, d);
        `CHK(d[7], 1'b0)
        bce <= 1'b0;
    endtask
    task automatic t_stop;
        wr(0, 8'h40);
        stop_mode <= 1'b1;
        rd_cnt(c);
        cyc(10);
        rd(1, h);
        rd(2, l1);
        `CHK({h, l1}, c)
        wr(4, 8'h09);
        stop_mode <= 1'b0;
        rd(4, d);
        `CHK(d, 8'h04)
    endtask
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {stop_mode, break_active, bce, pin} = 4'h0;
        req = '0;
        err_total = 0;
        num_checks = 0;
        cyc(2);
        rst_n <= 1'b1;
        t_reset;
        t_div;
        t_ext;
        t_latch;
        t_ovf;
        t_brk;
        t_stop;
        tally_and_finish;
    end
    // watchdog
    initial begin
        cyc(20000);
        err_total++;
        tally_and_finish;
    end
endmodule
